// ==== core/error_status_reporting.v ====
// error status register with upstream error message launch
// assumes enable registers live elsewhere and arrive as plain inputs
// assumes event inputs are pulses or levels in the clk domain
// assumes the link raises msg_ready in the cycle it takes a message
//
// Function
// - flag rise may send enabled message type
// - bit 13 set on bus strobe glitch
// - flags stay set until written one
// - bit 12 set on graphics software event
// - thermal bit set only when message sent
// - no thermal message while flag set
// - bit 9 set on locked nonmemory access
// - bit 8 set at 1024 queued refreshes
// - bit 7 set on memory throttling
// - bit 5 set on unimplemented completion
// - one condition yields at most one message
// - serr messages need global enable too
`timescale 1ns/10ps
`default_nettype none
`include "error_status_reporting_regs.vh"

module error_status_reporting #(
    parameter REFRESH_LIMIT = `ERR_REFRESH_LIMIT,
    parameter REFRESH_WIDTH = 11
) (
    // clock and synchronous reset
    input wire clk,
    input wire reset,
    // register port
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [15:0] reg_rdata_ff,
    // error conditions, one-cycle pulses
    input wire strobe_glitch_evt,
    input wire gfx_sw_smi_evt,
    input wire thermal_trip_evt,
    input wire locked_nonmemory_evt,
    input wire refresh_queued,
    input wire refresh_serviced,
    input wire memory_throttle_evt,
    input wire unimplemented_completion_evt,
    // enables kept in registers outside this block, one bit per flag
    input wire [15:0] serr_enable_register,
    input wire [15:0] smi_enable_register,
    input wire [15:0] sci_enable_register,
    input wire pci_serr_enable,
    // upstream error special cycle request
    output reg msg_valid_ff,
    output reg [2:0] msg_type_ff,
    output reg [3:0] msg_source_ff,
    input wire msg_ready,
    // level interrupt
    output reg irq_ff
);

    // implemented flag positions
    localparam [15:0] IMPL = `ERR_IMPL_MASK;

    reg [15:0] error_flags_ff;
    wire [15:0] nxt_error_flags;
    reg [15:0] irq_mask_ff;
    reg [15:0] pending_ff;
    reg [15:0] nxt_pending;
    reg [15:0] msg_count_ff;
    reg [6:0] last_msg_ff;
    reg [15:0] nxt_rdata;
    reg [2:0] launch_type;
    reg [3:0] launch_src;

    wire refresh_limit_hit;
    wire [15:0] event_vec;
    wire [15:0] clear_vec;
    wire [15:0] serr_route;
    wire [15:0] any_route;
    wire [15:0] flag_rise;
    wire thermal_would_send;
    wire launch;
    wire launch_go;
    wire flags_wr;
    wire mask_wr;
    wire thermal_routed;
    wire thermal_blocked;
    wire route_serr;
    wire route_smi;
    wire route_sci;
    wire [15:0] launch_clear;
    wire [15:0] new_pending;
    wire [15:0] irq_src;

    // lowest pending flag goes first
    function [3:0] first_bit;
        input [15:0] v;
        integer k;
        begin
            first_bit = 4'h0;
            for (k = 15; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    first_bit = k[3:0];
                end
            end
        end
    endfunction

    refresh_backlog_counter #(
        .LIMIT(REFRESH_LIMIT),
        .WIDTH(REFRESH_WIDTH)
    ) u_refresh_backlog (
        .clk(clk),
        .reset(reset),
        .refresh_queued(refresh_queued),
        .refresh_serviced(refresh_serviced),
        .limit_reached_ff(refresh_limit_hit)
    );

    // serr gated by the global enable
    assign serr_route = serr_enable_register & {16{pci_serr_enable}};
    assign any_route = serr_route | smi_enable_register | sci_enable_register;

    assign thermal_routed = any_route[`ERR_BIT_THERMAL];
    assign thermal_blocked = error_flags_ff[`ERR_BIT_THERMAL];
    assign thermal_would_send = thermal_trip_evt && thermal_routed && !thermal_blocked;

    // map each condition onto its flag position; reserved stay zero
    // strobe glitch
    assign event_vec[`ERR_BIT_STROBE_GLITCH] = strobe_glitch_evt;
    assign event_vec[`ERR_BIT_GFX_SW_SMI] = gfx_sw_smi_evt;
    assign event_vec[`ERR_BIT_THERMAL] = thermal_would_send;
    assign event_vec[`ERR_BIT_LOCKED_NONMEM] = locked_nonmemory_evt;
    assign event_vec[`ERR_BIT_REFRESH_TIMEOUT] = refresh_limit_hit;
    assign event_vec[`ERR_BIT_MEM_THROTTLE] = memory_throttle_evt;
    assign event_vec[`ERR_BIT_UNIMPL_COMPLETION] = unimplemented_completion_evt;
    // reserved positions never set
    assign event_vec[15:14] = 2'b00;
    assign event_vec[10] = 1'b0;
    assign event_vec[6] = 1'b0;
    assign event_vec[4:0] = 5'h00;

    // register write decode
    assign flags_wr = reg_write && (reg_addr == `ERR_FLAGS_OFFSET);
    assign mask_wr = reg_write && (reg_addr == `ERR_IRQ_MASK_OFFSET);

    assign clear_vec = flags_wr ? reg_wdata : 16'h0000;

    // per-flag sticky update; set wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_flag
            wire held;
            wire hit;
            assign held = error_flags_ff[gi] & ~clear_vec[gi];
            // a new event beats the clear
            assign hit = event_vec[gi];
            assign nxt_error_flags[gi] = IMPL[gi] & (held | hit);
        end
    endgenerate

    // message only on a zero to one step
    assign flag_rise = nxt_error_flags & ~error_flags_ff;

    // a new message may start when the link slot is free or handed off
    assign launch = (|pending_ff) && (!msg_valid_ff || msg_ready);

    // index of the next flag to send
    always @* begin
        launch_src = first_bit(pending_ff);
    end

    // route bits of the flag that goes next
    assign route_serr = serr_route[launch_src];
    assign route_smi = smi_enable_register[launch_src];
    assign route_sci = sci_enable_register[launch_src];

    // one message type per condition, serr first
    always @* begin
        if (route_serr) begin
            launch_type = `ERR_MSG_SERR;
        end else if (route_smi) begin
            launch_type = `ERR_MSG_SMI;
        end else if (route_sci) begin
            launch_type = `ERR_MSG_SCI;
        end else begin
            launch_type = `ERR_MSG_NONE;
        end
    end

    // a launch with no route left only drops the pending bit
    assign launch_go = launch && (launch_type != `ERR_MSG_NONE);

    // bit handed to the link this cycle
    assign launch_clear = launch ? (16'h0001 << launch_src) : 16'h0000;

    // queue rises that have an enabled route
    assign new_pending = flag_rise & any_route;

    // a fresh rise beats its own launch clear
    always @* begin
        nxt_pending = (pending_ff & ~launch_clear) | new_pending;
    end

    // irq sources, next flags under the current mask
    assign irq_src = nxt_error_flags & irq_mask_ff;

    always @(posedge clk) begin
        if (reset) begin
            error_flags_ff <= `ERR_FLAGS_RESET;
        end else begin
            error_flags_ff <= nxt_error_flags;
        end
    end

    // interrupt mask register
    always @(posedge clk) begin
        if (reset) begin
            irq_mask_ff <= `ERR_IRQ_MASK_RESET;
        end else if (mask_wr) begin
            irq_mask_ff <= reg_wdata & IMPL; // reserved bits stay zero
        end
    end

    // level interrupt, same cycle as the flag
    always @(posedge clk) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |irq_src;
        end
    end

    // pending rises, one bit per flag
    always @(posedge clk) begin
        if (reset) begin
            pending_ff <= 16'h0000;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    // upstream message launch and hold until accepted
    always @(posedge clk) begin
        if (reset) begin
            msg_valid_ff <= 1'b0;
            msg_type_ff <= `ERR_MSG_NONE;
            msg_source_ff <= 4'h0;
        end else if (launch_go) begin
            msg_valid_ff <= 1'b1;
            msg_type_ff <= launch_type;
            msg_source_ff <= launch_src;
        end else if (msg_ready) begin
            msg_valid_ff <= 1'b0;
        end
    end

    // message count and last message for software
    always @(posedge clk) begin
        if (reset) begin
            msg_count_ff <= 16'h0000;
            last_msg_ff <= 7'h00;
        end else if (launch_go) begin
            msg_count_ff <= msg_count_ff + 16'h0001; // wraps at full scale
            last_msg_ff <= {launch_type, launch_src};
        end
    end

    // read mux, unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `ERR_FLAGS_OFFSET: nxt_rdata = error_flags_ff;
            `ERR_IRQ_MASK_OFFSET: nxt_rdata = irq_mask_ff;
            `ERR_MSG_COUNT_OFFSET: nxt_rdata = msg_count_ff;
            `ERR_LAST_MSG_OFFSET: nxt_rdata = {9'h000, last_msg_ff};
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata_ff <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= 16'h0000;
        end
    end

endmodule // error_status_reporting

`default_nettype wire

// ==== inc/error_status_reporting_regs.vh ====
// register offsets, field positions, reset values and counts for the
// error status reporting block; definitions only, included by bare name
`ifndef ERROR_STATUS_REPORTING_REGS_VH
`define ERROR_STATUS_REPORTING_REGS_VH

// register offsets on the plain register port
`define ERR_FLAGS_OFFSET 8'h62
`define ERR_IRQ_MASK_OFFSET 8'h6c
`define ERR_MSG_COUNT_OFFSET 8'h6e
`define ERR_LAST_MSG_OFFSET 8'h70

// flag bit positions inside error_flags
`define ERR_BIT_STROBE_GLITCH 13
`define ERR_BIT_GFX_SW_SMI 12
`define ERR_BIT_THERMAL 11
`define ERR_BIT_LOCKED_NONMEM 9
`define ERR_BIT_REFRESH_TIMEOUT 8
`define ERR_BIT_MEM_THROTTLE 7
`define ERR_BIT_UNIMPL_COMPLETION 5

// implemented flag bits; every other position is reserved
`define ERR_IMPL_MASK 16'h3ba0
`define ERR_FLAGS_RESET 16'h0000
`define ERR_IRQ_MASK_RESET 16'h0000

// message type codes, one-hot except none, which is zero
`define ERR_MSG_NONE 3'h0
`define ERR_MSG_SERR 3'h1
`define ERR_MSG_SMI 3'h2
`define ERR_MSG_SCI 3'h4

// queued refreshes that raise the refresh timeout flag
`define ERR_REFRESH_LIMIT 1024

`endif

// ==== core/refresh_backlog_counter.v ====
// counter of queued memory core refreshes with a threshold flag
// assumes one queue and one service pulse at most per cycle each
`timescale 1ns/10ps
`default_nettype none

module refresh_backlog_counter #(
    parameter LIMIT = 1024,
    parameter WIDTH = 11
) (
    input wire clk,
    input wire reset,
    input wire refresh_queued,
    input wire refresh_serviced,
    output reg limit_reached_ff
);

    localparam [WIDTH-1:0] LIMIT_W = LIMIT[WIDTH-1:0];

    reg [WIDTH-1:0] count_ff;
    reg [WIDTH-1:0] nxt_count;

    // up on queue, down on service, saturating at the limit and at zero
    always @* begin
        nxt_count = count_ff;
        if (refresh_queued && !refresh_serviced && count_ff != LIMIT_W) begin
            nxt_count = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end else if (refresh_serviced && !refresh_queued && count_ff != {WIDTH{1'b0}}) begin
            nxt_count = count_ff - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // count and threshold flop
    always @(posedge clk) begin
        if (reset) begin
            count_ff <= {WIDTH{1'b0}};
            limit_reached_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            limit_reached_ff <= (nxt_count == LIMIT_W);
        end
    end

endmodule // refresh_backlog_counter

`default_nettype wire

// ==== dv/err_chk.sv ====
// port checker for the error status reporting block
// assumes one clock and the synchronous high reset
`timescale 1ns/10ps
`default_nettype none
`include "error_status_reporting_regs.vh"
module err_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata_ff,
    input wire logic [15:0] serr_enable_register,
    input wire logic pci_serr_enable,
    input wire logic msg_valid_ff,
    input wire logic [2:0] msg_type_ff,
    input wire logic [3:0] msg_source_ff,
    input wire logic msg_ready,
    input wire logic irq_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // message handshake and content
    a_valid_holds: assert property (msg_valid_ff && !msg_ready |=> msg_valid_ff)
        else $error("message dropped before accept");
    a_msg_stable: assert property (msg_valid_ff && !msg_ready |=> $stable({msg_type_ff, msg_source_ff}))
        else $error("message changed while waiting");
    a_type_onehot: assert property (msg_valid_ff |-> $onehot(msg_type_ff))
        else $error("message type not single");
    a_serr_gate: assert property ($rose(msg_valid_ff) && msg_type_ff == `ERR_MSG_SERR |-> $past(pci_serr_enable))
        else $error("serr sent without global enable");
    a_serr_route: assert property ($rose(msg_valid_ff) && msg_type_ff == `ERR_MSG_SERR
        |-> (($past(serr_enable_register) >> msg_source_ff) & 16'h0001) != 16'h0000)
        else $error("serr sent for unrouted flag");
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !msg_valid_ff && !irq_ff)
        else $error("outputs active after reset");
    a_rdata_idle: assert property (!reg_read |=> reg_rdata_ff == 16'h0000)
        else $error("read data without read");
    a_reserved_zero: assert property (reg_read && reg_addr == `ERR_FLAGS_OFFSET
        |=> (reg_rdata_ff & ~`ERR_IMPL_MASK) == 16'h0000)
        else $error("reserved flag bit read nonzero");
    // main scenarios reached
    c_msg_sent: cover property (msg_valid_ff && msg_ready);
    c_msg_stall: cover property (msg_valid_ff && !msg_ready);
    c_irq: cover property ($rose(irq_ff));
endmodule // err_chk
bind error_status_reporting err_chk u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_rdata_ff(reg_rdata_ff), .serr_enable_register(serr_enable_register),
    .pci_serr_enable(pci_serr_enable), .msg_valid_ff(msg_valid_ff), .msg_type_ff(msg_type_ff),
    .msg_source_ff(msg_source_ff), .msg_ready(msg_ready), .irq_ff(irq_ff));
`default_nettype wire

// ==== dv/hub_link_sink.sv ====
// upstream link receiver model taking error messages
// assumes the bench holds stall high to refuse messages
`timescale 1ns/10ps
`default_nettype none
module hub_link_sink (
    input wire logic clk,
    input wire logic reset,
    input wire logic stall,
    input wire logic msg_valid,
    input wire logic [2:0] msg_type,
    input wire logic [3:0] msg_source,
    output logic msg_ready,
    output logic [7:0] got_count,
    output logic [6:0] got_last
);
    // ready follows the stall request
    assign msg_ready = !stall;
    // record each accepted message
    always @(posedge clk) begin
        if (reset) begin
            got_count <= 8'h00;
            got_last <= 7'h00;
        end else if (msg_valid && msg_ready) begin
            got_count <= got_count + 8'h01;
            got_last <= {msg_type, msg_source};
        end
    end
endmodule // hub_link_sink
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the error status reporting block
// assumes the link model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, pci = 1'b0, stall = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] cnt;
    logic [15:0] wdata = 16'h0000, ev = 16'h0000, serr_en = 16'h0000;
    logic [15:0] smi_en = 16'h0000, sci_en = 16'h0000, rdata;
    logic [2:0] mtype;
    logic [3:0] msrc;
    logic [6:0] last;
    logic msg_valid, msg_ready, irq;
    int bad_count = 0, checked = 0, cycles = 0;
    int bits[5] = '{13, 12, 9, 7, 5};
    // clock and run ceiling
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end
    error_status_reporting #(.REFRESH_LIMIT(4), .REFRESH_WIDTH(3)) dut (.clk(clk), .reset(reset),
        .reg_addr(addr), .reg_wdata(wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata_ff(rdata), .strobe_glitch_evt(ev[13]), .gfx_sw_smi_evt(ev[12]),
        .thermal_trip_evt(ev[11]), .locked_nonmemory_evt(ev[9]), .refresh_queued(ev[8]),
        .refresh_serviced(ev[6]), .memory_throttle_evt(ev[7]),
        .unimplemented_completion_evt(ev[5]), .serr_enable_register(serr_en),
        .smi_enable_register(smi_en), .sci_enable_register(sci_en), .pci_serr_enable(pci),
        .msg_valid_ff(msg_valid), .msg_type_ff(mtype), .msg_source_ff(msrc),
        .msg_ready(msg_ready), .irq_ff(irq));
    hub_link_sink link (.clk(clk), .reset(reset), .stall(stall), .msg_valid(msg_valid),
        .msg_type(mtype), .msg_source(msrc), .msg_ready(msg_ready), .got_count(cnt),
        .got_last(last));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (exp !== got) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk("read", exp, rdata);
    endtask
    task automatic pulse(input logic [15:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 16'h0000;
        settle(4);
    endtask
    task automatic t_reset;
        rd(8'h62, 16'h0000);
        rd(8'h6c, 16'h0000);
        rd(8'h00, 16'h0000);
    endtask
    task automatic t_flags;
        foreach (bits[i]) begin
            pulse(16'h0001 << bits[i]);
            rd(8'h62, 16'h0001 << bits[i]);
            wr(8'h62, ~(16'h0001 << bits[i]));
            rd(8'h62, 16'h0001 << bits[i]);
            wr(8'h62, 16'h0001 << bits[i]);
            rd(8'h62, 16'h0000);
        end
    endtask
    task automatic t_refresh;
        repeat (3) pulse(16'h0100);
        rd(8'h62, 16'h0000);
        pulse(16'h0100);
        rd(8'h62, 16'h0100);
        pulse(16'h0040);
        wr(8'h62, 16'h0100);
        rd(8'h62, 16'h0000);
    endtask
    task automatic t_msg;
        @(posedge clk) {serr_en, pci, stall} <= {16'h2000, 2'b11};
        pulse(16'h2000);
        chk("valid", 16'h0001, {15'h0000, msg_valid});
        chk("count", 16'h0000, {8'h00, cnt});
        @(posedge clk) stall <= 1'b0;
        settle(3);
        chk("count", 16'h0001, {8'h00, cnt});
        chk("last", {9'h000, 3'h1, 4'hd}, {9'h000, last});
        wr(8'h62, 16'h2000);
        @(posedge clk) pci <= 1'b0;
        pulse(16'h2000);
        chk("count", 16'h0001, {8'h00, cnt});
        wr(8'h62, 16'h2000);
        @(posedge clk) {serr_en, smi_en} <= {16'h0000, 16'h1000};
        pulse(16'h1000);
        chk("last", {8'h02, 1'b0, 3'h2, 4'hc}, {cnt, 1'b0, last});
        wr(8'h62, 16'h1000);
    endtask
    task automatic t_thermal;
        pulse(16'h0800);
        rd(8'h62, 16'h0000);
        @(posedge clk) sci_en <= 16'h0800;
        pulse(16'h0800);
        rd(8'h62, 16'h0800);
        chk("last", {8'h03, 1'b0, 3'h4, 4'hb}, {cnt, 1'b0, last});
        rd(8'h6e, 16'h0003);
        rd(8'h70, 16'h004b);
        pulse(16'h0800);
        chk("count", 16'h0003, {8'h00, cnt});
        wr(8'h62, 16'h0800);
        rd(8'h62, 16'h0000);
    endtask
    task automatic t_irq;
        pulse(16'h0080);
        chk("irq", 16'h0000, {15'h0000, irq});
        wr(8'h6c, 16'h0080);
        settle(2);
        chk("irq", 16'h0001, {15'h0000, irq});
        wr(8'h62, 16'h0080);
        settle(2);
        chk("irq", 16'h0000, {15'h0000, irq});
        rd(8'h6c, 16'h0080);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_flags();
        t_refresh();
        t_msg();
        t_thermal();
        t_irq();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
